// file: design/bridge_ctrl_pkg.sv
// Overview of operation
// - bits 31:28 reserved, writes ignored, read as zero
// - bit 27 set: discard timer expiry pulls primary system error low
// - bit 27 has no effect in PCI-X mode
// - bit 26 sets on discard error, write one clears, zero in PCI-X
// - bit 25 picks secondary discard length, long or short, ignored in PCI-X
// - bit 24 picks primary discard length, long or short, ignored in PCI-X
// - bit 23 read-only zero, no fast back-to-back cycles
// - bit 22 set holds the secondary bus reset asserted
// - bit 21 clear: master aborts unreported, reads all-ones, writes dropped
// - bit 21 set: target abort if possible, else system error if enabled
// - PCI-X non-posted master abort returns a split completion message
// - bit 19 clear: VGA addresses forwarded only inside programmed windows
// - bit 19 set: VGA addresses forwarded whenever I/O or memory enabled
// - bit 18 clear: all I/O inside base/limit forwarded downstream
// - bit 18 set: in-window I/O in first 64KB forwarded upstream
// - bit 17 set: secondary system error passed to primary system error
// - bit 16 set enables secondary parity error detection
// - bit 20 reserved, reads as zero
package bridge_ctrl_pkg;
  localparam logic [7:0]  BRIDGE_CONTROL_OFS = 8'h3c;
  localparam int          CTRL_LSB           = 16;
  localparam int          CTRL_W             = 16;
  localparam int          BIT_PAR_EN         = 0;
  localparam int          BIT_SSERR_FWD      = 1;
  localparam int          BIT_ISA_EN         = 2;
  localparam int          BIT_VGA_EN         = 3;
  localparam int          BIT_RSVD20         = 4;
  localparam int          BIT_MA_MODE        = 5;
  localparam int          BIT_SEC_RST        = 6;
  localparam int          BIT_FBB            = 7;
  localparam int          BIT_PRI_SHORT      = 8;
  localparam int          BIT_SEC_SHORT      = 9;
  localparam int          BIT_DT_STATUS      = 10;
  localparam int          BIT_DT_SERR_EN     = 11;
  // plain read/write bits; 26 is write-one-clear, the rest stay zero
  localparam logic [15:0] CTRL_RW_MASK       = 16'h0b6f;
  localparam logic [15:0] CTRL_RESET         = 16'h0000;
  localparam int          TIMER_W            = 16;
  localparam logic [15:0] DISCARD_SHORT      = 16'h0400;
  localparam int          LONG_DISCARD_DEF   = 32768;
  localparam logic [31:0] ALL_ONES           = 32'hffffffff;
  localparam logic [31:0] VGA_MEM_LO         = 32'h000a0000;
  localparam logic [31:0] VGA_MEM_HI         = 32'h000bffff;
  localparam logic [9:0]  VGA_IO_A_LO        = 10'h3b0;
  localparam logic [9:0]  VGA_IO_A_HI        = 10'h3bb;
  localparam logic [9:0]  VGA_IO_B_LO        = 10'h3c0;
  localparam logic [9:0]  VGA_IO_B_HI        = 10'h3df;
  localparam logic [15:0] IO_64K_TOP         = 16'h0000;
endpackage

// file: design/vga_isa_decode.sv
`timescale 1ns/100ps
`default_nettype none
module vga_isa_decode (
  input  wire logic        is_io_in,
  input  wire logic [31:0] addr_in,
  input  wire logic        window_hit_in,
  input  wire logic        io_enable_in,
  input  wire logic        mem_enable_in,
  input  wire logic        vga_enable_in,
  input  wire logic        isa_enable_in,
  output wire logic        fwd_down_out,
  output wire logic        fwd_up_isa_out
);
  wire logic [9:0] io_low10;
  wire logic       vga_io;
  wire logic       vga_mem;
  wire logic       in_first_64k;
  wire logic       isa_up;
  wire logic       io_down;
  wire logic       mem_down;

  // upper address bits are ignored so every 10-bit alias matches
  assign io_low10 = addr_in[9:0];
  assign vga_io = ((io_low10 >= bridge_ctrl_pkg::VGA_IO_A_LO) &&
                   (io_low10 <= bridge_ctrl_pkg::VGA_IO_A_HI)) ||
                  ((io_low10 >= bridge_ctrl_pkg::VGA_IO_B_LO) &&
                   (io_low10 <= bridge_ctrl_pkg::VGA_IO_B_HI));
  assign vga_mem = (addr_in >= bridge_ctrl_pkg::VGA_MEM_LO) &&
                   (addr_in <= bridge_ctrl_pkg::VGA_MEM_HI);
  assign in_first_64k = (addr_in[31:16] == bridge_ctrl_pkg::IO_64K_TOP);
  assign isa_up = isa_enable_in && window_hit_in && in_first_64k;
  // VGA forwarding beats the ISA upstream steering
  assign io_down = io_enable_in &&
                   ((window_hit_in && !isa_up) ||
                    (vga_enable_in && vga_io));
  assign mem_down = mem_enable_in &&
                    (window_hit_in || (vga_enable_in && vga_mem));
  assign fwd_down_out = is_io_in ? io_down : mem_down;
  assign fwd_up_isa_out = is_io_in && isa_up && !(vga_enable_in && vga_io);
endmodule
`default_nettype wire

// file: design/bridge_control_register.sv
`timescale 1ns/100ps
`default_nettype none
module bridge_control_register #(
  parameter int LONG_DISCARD_CYCLES = bridge_ctrl_pkg::LONG_DISCARD_DEF
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // configuration access from the primary bus target
  input  wire logic        cfg_wr_in,
  input  wire logic        cfg_rd_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [3:0]  cfg_be_in,
  input  wire logic [31:0] cfg_wdata_in,
  output logic      [31:0] cfg_rdata_out,
  output logic             cfg_rvalid_out,
  // bridge mode and command register bits
  input  wire logic        primary_pcix_in,
  input  wire logic        secondary_pcix_in,
  input  wire logic        serr_enable_in,
  input  wire logic        io_enable_in,
  input  wire logic        mem_enable_in,
  // discard timers
  input  wire logic        primary_discard_expired_in,
  input  wire logic        secondary_discard_expired_in,
  output logic      [15:0] primary_discard_limit_out,
  output logic      [15:0] secondary_discard_limit_out,
  // system error pins
  input  wire logic        secondary_system_error_n_in,
  output logic             primary_system_error_n_out,
  output logic             secondary_bus_reset_n_out,
  // master abort handling
  input  wire logic        master_abort_in,
  input  wire logic        master_abort_read_in,
  input  wire logic        master_abort_posted_in,
  input  wire logic        target_abort_possible_in,
  output logic             ma_target_abort_out,
  output logic             ma_all_ones_out,
  output logic             ma_discard_write_out,
  output logic             ma_split_complete_out,
  output logic             fast_b2b_enable_out,
  // address forwarding decision
  input  wire logic        fwd_valid_in,
  input  wire logic        fwd_is_io_in,
  input  wire logic [31:0] fwd_addr_in,
  input  wire logic        fwd_window_hit_in,
  output logic             fwd_down_out,
  output logic             fwd_up_isa_out,
  // secondary parity
  input  wire logic        secondary_parity_error_in,
  output logic             secondary_parity_error_out
);
  localparam logic [15:0] LONG_LIMIT = LONG_DISCARD_CYCLES[15:0];

  logic [15:0] ctrl_q;
  logic [31:0] rdata_q;
  logic        rvalid_q;
  logic        sserr_meta_q;
  logic        sserr_sync_q;
  logic        pserr_n_q;
  logic        sec_rst_n_q;
  logic [15:0] pri_limit_q;
  logic [15:0] sec_limit_q;
  logic        ma_tabort_q;
  logic        ma_ones_q;
  logic        ma_drop_q;
  logic        ma_split_q;
  logic        fwd_down_q;
  logic        fwd_up_q;
  logic        par_err_q;

  wire logic        addr_hit;
  wire logic        wr_hit;
  wire logic        rd_hit;
  wire logic [15:0] lane_wr;
  wire logic        dt_expired;
  wire logic        dt_set;
  wire logic        dt_clear;
  wire logic        dt_serr;
  wire logic        sserr_fwd;
  wire logic        ma_report;
  wire logic        ma_serr;
  wire logic        pserr_assert;
  wire logic [31:0] read_word;
  wire logic        dec_down;
  wire logic        dec_up;
  wire logic [15:0] ctrl_d;
  wire logic        pri_short;
  wire logic        sec_short;
  wire logic [15:0] pri_limit_d;
  wire logic [15:0] sec_limit_d;
  wire logic        ma_quiet;
  wire logic        ma_tabort_d;
  wire logic        ma_ones_d;
  wire logic        ma_drop_d;
  wire logic        ma_split_d;
  wire logic        fwd_down_d;
  wire logic        fwd_up_d;
  wire logic        par_err_d;

  assign addr_hit = (cfg_addr_in == bridge_ctrl_pkg::BRIDGE_CONTROL_OFS);
  assign wr_hit = cfg_wr_in && addr_hit;
  assign rd_hit = cfg_rd_in && addr_hit;
  // byte lane 2 covers bits 23:16, lane 3 covers bits 31:24
  assign lane_wr = {{8{wr_hit && cfg_be_in[3]}}, {8{wr_hit && cfg_be_in[2]}}};

  // plain read/write bits; reserved and read-only bits never load
  genvar i;
  generate
    for (i = 0; i < bridge_ctrl_pkg::CTRL_W; i++) begin : g_bit
      if (bridge_ctrl_pkg::CTRL_RW_MASK[i]) begin : g_rw
        assign ctrl_d[i] = lane_wr[i] ?
                           cfg_wdata_in[bridge_ctrl_pkg::CTRL_LSB + i] :
                           ctrl_q[i];
      end else if (i == bridge_ctrl_pkg::BIT_DT_STATUS) begin : g_w1c
        // hardware set wins over a clear in the same cycle
        assign ctrl_d[i] = primary_pcix_in ? 1'b0 :
                           (dt_set || (ctrl_q[i] && !dt_clear));
      end else begin : g_ro
        assign ctrl_d[i] = 1'b0;
      end
    end
  endgenerate

  assign dt_expired = primary_discard_expired_in || secondary_discard_expired_in;
  assign dt_set = dt_expired;
  assign dt_clear = lane_wr[bridge_ctrl_pkg::BIT_DT_STATUS] &&
                    cfg_wdata_in[bridge_ctrl_pkg::CTRL_LSB +
                                 bridge_ctrl_pkg::BIT_DT_STATUS];
  assign dt_serr = dt_expired && !primary_pcix_in &&
                   ctrl_q[bridge_ctrl_pkg::BIT_DT_SERR_EN];

  // the synchroniser output, not its first stage, feeds the forwarding term
  assign sserr_fwd = !sserr_sync_q &&
                     ctrl_q[bridge_ctrl_pkg::BIT_SSERR_FWD];

  assign ma_report = master_abort_in && !primary_pcix_in &&
                     ctrl_q[bridge_ctrl_pkg::BIT_MA_MODE];
  assign ma_serr = ma_report && !target_abort_possible_in &&
                   serr_enable_in;
  assign pserr_assert = dt_serr || sserr_fwd || ma_serr;

  // a PCI-X interface ignores its length bit, so the long default stays there
  assign pri_short = ctrl_q[bridge_ctrl_pkg::BIT_PRI_SHORT] && !primary_pcix_in;
  assign sec_short = ctrl_q[bridge_ctrl_pkg::BIT_SEC_SHORT] && !secondary_pcix_in;
  assign pri_limit_d = pri_short ? bridge_ctrl_pkg::DISCARD_SHORT : LONG_LIMIT;
  assign sec_limit_d = sec_short ? bridge_ctrl_pkg::DISCARD_SHORT : LONG_LIMIT;

  assign ma_quiet = master_abort_in && !primary_pcix_in &&
                    !ctrl_q[bridge_ctrl_pkg::BIT_MA_MODE];
  assign ma_tabort_d = ma_report && target_abort_possible_in;
  assign ma_ones_d = ma_quiet && master_abort_read_in;
  assign ma_drop_d = ma_quiet && !master_abort_read_in;
  assign ma_split_d = master_abort_in && primary_pcix_in &&
                      !master_abort_posted_in;

  assign fwd_down_d = fwd_valid_in && dec_down;
  assign fwd_up_d = fwd_valid_in && dec_up;
  assign par_err_d = secondary_parity_error_in &&
                     ctrl_q[bridge_ctrl_pkg::BIT_PAR_EN];

  // interrupt line and pin bytes live elsewhere and read zero here
  assign read_word = {ctrl_q, 16'h0000};

  vga_isa_decode u_decode (
    .is_io_in       (fwd_is_io_in),
    .addr_in        (fwd_addr_in),
    .window_hit_in  (fwd_window_hit_in),
    .io_enable_in   (io_enable_in),
    .mem_enable_in  (mem_enable_in),
    .vga_enable_in  (ctrl_q[bridge_ctrl_pkg::BIT_VGA_EN]),
    .isa_enable_in  (ctrl_q[bridge_ctrl_pkg::BIT_ISA_EN]),
    .fwd_down_out   (dec_down),
    .fwd_up_isa_out (dec_up)
  );

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ctrl_q <= bridge_ctrl_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= 32'h00000000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rd_hit ? read_word : 32'h00000000;
      rvalid_q <= rd_hit;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sserr_meta_q <= 1'b1;
      sserr_sync_q <= 1'b1;
    end else begin
      sserr_meta_q <= secondary_system_error_n_in;
      sserr_sync_q <= sserr_meta_q;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pserr_n_q <= 1'b1;
      sec_rst_n_q <= 1'b0;
    end else begin
      pserr_n_q <= !pserr_assert;
      sec_rst_n_q <= !ctrl_q[bridge_ctrl_pkg::BIT_SEC_RST];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pri_limit_q <= LONG_LIMIT;
      sec_limit_q <= LONG_LIMIT;
    end else begin
      pri_limit_q <= pri_limit_d;
      sec_limit_q <= sec_limit_d;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ma_tabort_q <= 1'b0;
      ma_ones_q <= 1'b0;
      ma_drop_q <= 1'b0;
      ma_split_q <= 1'b0;
    end else begin
      ma_tabort_q <= ma_tabort_d;
      ma_ones_q <= ma_ones_d;
      ma_drop_q <= ma_drop_d;
      ma_split_q <= ma_split_d;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      fwd_down_q <= 1'b0;
      fwd_up_q <= 1'b0;
    end else begin
      fwd_down_q <= fwd_down_d;
      fwd_up_q <= fwd_up_d;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      par_err_q <= 1'b0;
    end else begin
      par_err_q <= par_err_d;
    end
  end

  assign cfg_rdata_out = rdata_q;
  assign cfg_rvalid_out = rvalid_q;
  assign primary_discard_limit_out = pri_limit_q;
  assign secondary_discard_limit_out = sec_limit_q;
  assign primary_system_error_n_out = pserr_n_q;
  assign secondary_bus_reset_n_out = sec_rst_n_q;
  assign ma_target_abort_out = ma_tabort_q;
  assign ma_all_ones_out = ma_ones_q;
  assign ma_discard_write_out = ma_drop_q;
  assign ma_split_complete_out = ma_split_q;
  // bit 23 is a constant zero register bit, so this output never rises
  assign fast_b2b_enable_out = ctrl_q[bridge_ctrl_pkg::BIT_FBB];
  assign fwd_down_out = fwd_down_q;
  assign fwd_up_isa_out = fwd_up_q;
  assign secondary_parity_error_out = par_err_q;
endmodule
`default_nettype wire

// file: dv/bridge_control_register_sva.sv
`timescale 1ns/100ps
`default_nettype none
module bridge_control_register_sva #(
  parameter int LONG_DISCARD_CYCLES = 32768
) (
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic        cfg_rd_in,
  input wire logic        cfg_wr_in,
  input wire logic [7:0]  cfg_addr_in,
  input wire logic [3:0]  cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic        cfg_rvalid_out,
  input wire logic        primary_pcix_in,
  input wire logic        master_abort_in,
  input wire logic        master_abort_read_in,
  input wire logic        master_abort_posted_in,
  input wire logic        target_abort_possible_in,
  input wire logic        ma_target_abort_out,
  input wire logic        ma_all_ones_out,
  input wire logic        ma_split_complete_out,
  input wire logic        fast_b2b_enable_out,
  input wire logic        secondary_bus_reset_n_out,
  input wire logic [15:0] primary_discard_limit_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_rd_answer: assert property (cfg_rvalid_out |->
    $past(cfg_rd_in && cfg_addr_in == 8'h3c)) else $error("read answer without read");
  chk_rsvd_zero: assert property (cfg_rvalid_out |-> cfg_rdata_out[31:28] == 4'h0)
    else $error("reserved high bits read nonzero");
  chk_fbb_zero: assert property (!fast_b2b_enable_out &&
    !(cfg_rvalid_out && cfg_rdata_out[23])) else $error("fast back to back seen");
  chk_bit20_zero: assert property (cfg_rvalid_out |-> !cfg_rdata_out[20])
    else $error("bit 20 read nonzero");
  chk_pcix_status: assert property (cfg_rvalid_out && $past(primary_pcix_in) &&
    $past(primary_pcix_in, 2) |-> !cfg_rdata_out[26]) else $error("status set in pcix");
  chk_sec_reset: assert property (cfg_wr_in && cfg_addr_in == 8'h3c && cfg_be_in[2] &&
    cfg_wdata_in[22] |-> ##2 !secondary_bus_reset_n_out) else $error("no sec reset");
  chk_ma_ones: assert property (ma_all_ones_out |-> $past(master_abort_in &&
    master_abort_read_in && !primary_pcix_in)) else $error("stray all ones");
  chk_ma_target: assert property (ma_target_abort_out |-> $past(master_abort_in &&
    target_abort_possible_in && !primary_pcix_in)) else $error("stray target abort");
  chk_ma_split: assert property (ma_split_complete_out |-> $past(master_abort_in &&
    primary_pcix_in && !master_abort_posted_in)) else $error("stray split");
  chk_limit_val: assert property (primary_discard_limit_out == 16'h0400 ||
    primary_discard_limit_out == LONG_DISCARD_CYCLES[15:0]) else $error("bad limit");
  chk_pcix_limit: assert property (primary_pcix_in |=>
    primary_discard_limit_out == LONG_DISCARD_CYCLES[15:0]) else $error("short limit in pcix");
endmodule
bind bridge_control_register bridge_control_register_sva #(
  .LONG_DISCARD_CYCLES(LONG_DISCARD_CYCLES)
) u_sva (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cfg_rd_in(cfg_rd_in),
  .cfg_wr_in(cfg_wr_in), .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in),
  .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out),
  .cfg_rvalid_out(cfg_rvalid_out), .primary_pcix_in(primary_pcix_in),
  .master_abort_in(master_abort_in), .master_abort_read_in(master_abort_read_in),
  .master_abort_posted_in(master_abort_posted_in),
  .target_abort_possible_in(target_abort_possible_in),
  .ma_target_abort_out(ma_target_abort_out), .ma_all_ones_out(ma_all_ones_out),
  .ma_split_complete_out(ma_split_complete_out),
  .fast_b2b_enable_out(fast_b2b_enable_out),
  .secondary_bus_reset_n_out(secondary_bus_reset_n_out),
  .primary_discard_limit_out(primary_discard_limit_out)
);
`default_nettype wire

// file: dv/cfg_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic        rvalid_in,
  output logic             wr_out,
  output logic             rd_out,
  output logic      [7:0]  addr_out,
  output logic      [3:0]  be_out,
  output logic      [31:0] wdata_out
);
  initial begin
    {wr_out, rd_out, addr_out, be_out, wdata_out} = '0;
  end
  // idle bus shows inverted values so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk_in) #1;
    {wr_out, addr_out, be_out, wdata_out} = {1'b1, a, b, d};
    @(posedge clk_in) #1;
    {wr_out, addr_out, wdata_out} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(posedge clk_in) #1;
    {rd_out, addr_out} = {1'b1, a};
    @(posedge clk_in) #1;
    {rd_out, addr_out} = {1'b0, ~a};
    v = rvalid_in;
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// file: dv/bridge_control_register_tb.sv
`timescale 1ns/100ps
`default_nettype none
module bridge_control_register_tb;
  logic        ref_clk_in, rst_n_in, cfg_wr_in, cfg_rd_in, primary_pcix_in, secondary_pcix_in;
  logic        serr_enable_in, io_enable_in, mem_enable_in, primary_discard_expired_in;
  logic        secondary_discard_expired_in, secondary_system_error_n_in, master_abort_in;
  logic        master_abort_read_in, master_abort_posted_in, target_abort_possible_in;
  logic        fwd_valid_in, fwd_is_io_in, fwd_window_hit_in, secondary_parity_error_in;
  logic [7:0]  cfg_addr_in;
  logic [3:0]  cfg_be_in;
  logic [31:0] cfg_wdata_in, fwd_addr_in;
  wire  [31:0] cfg_rdata_out;
  wire  [15:0] primary_discard_limit_out, secondary_discard_limit_out;
  wire         cfg_rvalid_out, primary_system_error_n_out, secondary_bus_reset_n_out;
  wire         ma_target_abort_out, ma_all_ones_out, ma_discard_write_out;
  wire         ma_split_complete_out, fast_b2b_enable_out, fwd_down_out, fwd_up_isa_out;
  wire         secondary_parity_error_out;
  int          n_fail, total_checks;
  logic [5:0]  ma_c [5] = '{6'h08, 6'h04, 6'h2a, 6'h29, 6'h18};
  logic [4:0]  ma_x [5] = '{5'h08, 5'h04, 5'h10, 5'h01, 5'h02};
  logic [5:0]  fw_c [7] = '{6'h0b, 6'h2b, 6'h22, 6'h1f, 6'h0f, 6'h33, 6'h3f};
  logic [31:0] fw_a [7] = '{32'h3c0, 32'h13c0, 32'ha0000, 32'h100, 32'h100, 32'hb0000,
                            32'h3b0};
  logic [1:0]  fw_x [7] = '{2'h0, 2'h2, 2'h0, 2'h1, 2'h2, 2'h2, 2'h2};
  // short discard count keeps the long limit visible in 16 bits
  bridge_control_register #(.LONG_DISCARD_CYCLES(64)) DUT (.*);
  cfg_host_model host (.clk_in(ref_clk_in), .rdata_in(cfg_rdata_out),
    .rvalid_in(cfg_rvalid_out), .wr_out(cfg_wr_in), .rd_out(cfg_rd_in),
    .addr_out(cfg_addr_in), .be_out(cfg_be_in), .wdata_out(cfg_wdata_in));
  initial begin
    ref_clk_in = 0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic tick;
    @(posedge ref_clk_in) #1;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input string n, input logic [31:0] e);
    logic [31:0] d;
    logic        v;
    host.rd(8'h3c, d, v);
    chk(n, e, d);
    chk(n, 32'h1, {31'h0, v});
  endtask
  task automatic t_access;
    logic [31:0] d;
    logic        v;
    chk("limit p", 16'h0040, primary_discard_limit_out);
    chk("limit s", 16'h0040, secondary_discard_limit_out);
    chk("sec rst", 1, secondary_bus_reset_n_out);
    rdc("reset val", 0);
    host.wr(8'h3c, 4'hf, 32'hffffffff);
    rdc("rw mask", 32'h0b6f0000);
    chk("short p", 16'h0400, primary_discard_limit_out);
    chk("short s", 16'h0400, secondary_discard_limit_out);
    chk("sec rst on", 0, secondary_bus_reset_n_out);
    {primary_pcix_in, secondary_pcix_in} = 2'h3;
    tick;
    chk("pcix p", 16'h0040, primary_discard_limit_out);
    chk("pcix s", 16'h0040, secondary_discard_limit_out);
    {primary_pcix_in, secondary_pcix_in} = 2'h0;
    host.wr(8'h38, 4'hf, 0);
    host.rd(8'h38, d, v);
    chk("unmapped", 0, {31'h0, v});
    host.wr(8'h3c, 4'h4, 0);
    rdc("lane2", 32'h0b000000);
    host.wr(8'h3c, 4'hc, 0);
    $display("test access done");
  endtask
  task automatic t_discard;
    host.wr(8'h3c, 4'h8, 32'h08000000);
    primary_discard_expired_in = 1;
    tick;
    primary_discard_expired_in = 0;
    chk("dt serr", 0, primary_system_error_n_out);
    tick;
    chk("dt serr end", 1, primary_system_error_n_out);
    rdc("dt status", 32'h0c000000);
    // a new expiry in the cycle of the clear keeps the flag set
    fork
      host.wr(8'h3c, 4'h8, 32'h0c000000);
      begin
        tick;
        secondary_discard_expired_in = 1;
        tick;
        secondary_discard_expired_in = 0;
      end
    join
    rdc("set wins", 32'h0c000000);
    host.wr(8'h3c, 4'h8, 32'h0c000000);
    rdc("w1c", 32'h08000000);
    primary_pcix_in = 1;
    tick;
    secondary_discard_expired_in = 1;
    tick;
    secondary_discard_expired_in = 0;
    chk("pcix serr", 1, primary_system_error_n_out);
    rdc("pcix status", 32'h08000000);
    primary_pcix_in = 0;
    $display("test discard done");
  endtask
  task automatic t_sserr;
    for (int e = 1; e >= 0; e--) begin
      host.wr(8'h3c, 4'hc, {14'h0, e[0], 17'h0});
      secondary_system_error_n_in = 0;
      repeat (3) tick;
      chk("sserr fwd", {31'h0, !e[0]}, primary_system_error_n_out);
      secondary_system_error_n_in = 1;
      repeat (4) tick;
      chk("sserr off", 1, primary_system_error_n_out);
    end
    $display("test sserr done");
  endtask
  task automatic t_mabort;
    for (int i = 0; i < 5; i++) begin
      host.wr(8'h3c, 4'hc, {10'h0, ma_c[i][5], 21'h0});
      {primary_pcix_in, master_abort_read_in, master_abort_posted_in,
       target_abort_possible_in, serr_enable_in} = ma_c[i][4:0];
      master_abort_in = 1;
      tick;
      master_abort_in = 0;
      chk("ma outs", ma_x[i], {ma_target_abort_out, ma_all_ones_out, ma_discard_write_out,
        ma_split_complete_out, !primary_system_error_n_out});
    end
    primary_pcix_in = 0;
    $display("test mabort done");
  endtask
  task automatic t_fwd;
    for (int i = 0; i < 7; i++) begin
      host.wr(8'h3c, 4'hc, {12'h0, fw_c[i][5:4], 18'h0});
      {fwd_is_io_in, fwd_window_hit_in, io_enable_in, mem_enable_in} = fw_c[i][3:0];
      fwd_addr_in = fw_a[i];
      fwd_valid_in = 1;
      tick;
      fwd_valid_in = 0;
      chk("fwd", fw_x[i], {fwd_down_out, fwd_up_isa_out});
    end
    for (int e = 1; e >= 0; e--) begin
      host.wr(8'h3c, 4'hc, {15'h0, e[0], 16'h0});
      secondary_parity_error_in = 1;
      tick;
      secondary_parity_error_in = 0;
      chk("parity", e[0], secondary_parity_error_out);
    end
    $display("test forward done");
  endtask
  task automatic t_reset;
    host.wr(8'h3c, 4'hc, 32'h0fff0000);
    primary_discard_expired_in = 1;
    tick;
    primary_discard_expired_in = 0;
    rst_n_in = 0;
    repeat (2) tick;
    chk("rst hold", 0, secondary_bus_reset_n_out);
    chk("rst serr", 1, primary_system_error_n_out);
    rst_n_in = 1;
    tick;
    chk("rst release", 1, secondary_bus_reset_n_out);
    chk("rst limit", 16'h0040, primary_discard_limit_out);
    rdc("rst val", 0);
    $display("test reset done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    {rst_n_in, primary_pcix_in, secondary_pcix_in, serr_enable_in, io_enable_in} = '0;
    {mem_enable_in, primary_discard_expired_in, secondary_discard_expired_in} = '0;
    {master_abort_in, master_abort_read_in, master_abort_posted_in} = '0;
    {target_abort_possible_in, fwd_valid_in, fwd_is_io_in, fwd_window_hit_in} = '0;
    {secondary_parity_error_in, fwd_addr_in, n_fail, total_checks} = '0;
    secondary_system_error_n_in = 1;
    repeat (16) tick;
    rst_n_in = 1;
    repeat (2) tick;
    t_access;
    t_discard;
    t_sserr;
    t_mabort;
    t_fwd;
    t_reset;
    end_sim;
  end
  // tests need well under a thousand cycles
  initial begin
    #50000;
    n_fail++;
    end_sim;
  end
endmodule
`default_nettype wire
